// [shared/radio_regs_consts.svh]
// Purpose: Offsets, field positions, reset values for the radio config block
// Assumes: Avalon word addressing, one 8-bit register per word
// Notes: Printed offsets are register indices; byte address is index * 4
`ifndef RADIO_REGS_CONSTS_SVH
`define RADIO_REGS_CONSTS_SVH
`define IDX_ANALOG_CONTROL 8'h20
`define IDX_CHANNEL_SELECT 8'h21
`define IDX_PROT_A 8'h2e
`define IDX_PROT_B 8'h2f
`define IDX_MFG_ID_FIRST 8'h3c
`define IDX_MFG_ID_LAST 8'h3f
`define IDX_LINK_STATUS 8'h30
`define BIT_REG_WRITE_EN 6
`define BIT_MFG_READ_EN 5
`define BIT_AMP_OUTPUT_ENABLE 2
`define BIT_AMP_INVERT 1
`define BIT_DEVICE_RESET 0
`define ANALOG_WRITABLE_MASK 8'h66
`define CHANNEL_WRITABLE_MASK 8'h7f
`define RST_ANALOG_CONTROL 8'h00
`define RST_CHANNEL_SELECT 8'h00
`define BASE_FREQ_MHZ 12'd2400
`define SOFT_RESET_CYCLES 4'd4
`endif

// [shared/radio_regs_pkg.sv]
// Purpose: Types shared by the radio config block
// Assumes: Nothing beyond the constants header
// Notes: Bus engine states
package radio_regs_pkg;
   typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER, BUS_DONE} bus_state_t;
   typedef logic [7:0] reg_byte_t;
endpackage

// [rtl/soft_reset_stretch.sv]
// Purpose: Stretch a one-cycle soft reset request into a reset window
// Assumes: Same clock as the register bank
// Notes: Busy stays high for the full window
`include "radio_regs_consts.svh"
module soft_reset_stretch
   import radio_regs_pkg::*;
#(
   parameter logic [3:0] CYCLES = `SOFT_RESET_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Request and window
   input wire logic start,
   output logic busy
);
   logic [3:0] count_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= 4'h0;
      end else if (start) begin
         count_reg <= CYCLES;
      end else if (count_reg != 4'h0) begin
         count_reg <= count_reg - 4'h1;
      end
   end

   assign busy = (count_reg != 4'h0);
endmodule

// [rtl/radio_analog_channel_regs.sv]
// Purpose: Analog control and channel registers of the radio, Avalon-MM slave
// Assumes: CLK_SYS at 200 MHz; host obeys reserved-bit and ordering duties
// Notes: Protected and ID register contents live outside; this block gates
// their strobes and reads. A soft reset blocks the bus for a short window;
// the host sees waitrequest held high and simply waits it out.
// Operation
// - Bit 6 set allows writes to registers 0x2E and 0x2F.
// - ID registers 0x3C-0x3F read back only while bit 5 set.
// - Bit 2 enables the amplifier control output pin.
// - Bit 1 selects amplifier pin polarity; 1 means active low.
// - Writing 1 to bit 0 resets all registers; bit self-clears.
// - Channel field sets synthesizer to 2400 MHz plus value.
`include "radio_regs_consts.svh"
module radio_analog_channel_regs
   import radio_regs_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_B,
   // Avalon-MM slave, word addressed
   input wire logic [ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic [1:0] AVS_RESPONSE,
   // Protected registers 0x2E/0x2F, stored outside
   input wire logic [7:0] PROT_A_RDATA,
   input wire logic [7:0] PROT_B_RDATA,
   output logic PROT_A_WE,
   output logic PROT_B_WE,
   output logic [7:0] PROT_WDATA,
   // Manufacturing identification words 0x3C-0x3F
   input wire logic [31:0] MFG_ID,
   output logic MFG_ID_POWER,
   // Radio side
   output logic amp_control_pin,
   output logic amp_control_pin_oe,
   output logic [6:0] SYNTH_CHANNEL,
   output logic [11:0] SYNTH_FREQ_MHZ,
   output logic DEVICE_RESET_B
);
   reg_byte_t analog_control_reg;
   reg_byte_t channel_select_reg;
   bus_state_t state_reg;
   logic [31:0] rdata_reg;
   logic [1:0] resp_reg;
   logic prot_a_we_reg;
   logic prot_b_we_reg;
   reg_byte_t prot_wdata_reg;
   logic amp_pin_reg;
   logic amp_oe_reg;
   logic [11:0] freq_reg;
   logic dev_rst_b_reg;
   logic soft_start;
   logic soft_busy;
   logic wr_taken;
   logic rd_taken;
   logic lane0;
   logic [7:0] idx;
   logic [31:0] rdata_next;
   logic [1:0] resp_next;
   logic hit_analog;
   logic hit_channel;
   logic hit_prot_a;
   logic hit_prot_b;
   logic hit_mfg;
   logic hit_status;
   logic req_taken;
   reg_byte_t mfg_byte;

   assign idx = AVS_ADDRESS[7:0];
   assign lane0 = AVS_BYTEENABLE[0];
   assign wr_taken = (state_reg == BUS_IDLE) && AVS_WRITE && !soft_busy;
   assign rd_taken = (state_reg == BUS_IDLE) && AVS_READ && !soft_busy;
   // Index decode, shared by the write and read paths
   assign hit_analog = (idx == `IDX_ANALOG_CONTROL);
   assign hit_channel = (idx == `IDX_CHANNEL_SELECT);
   assign hit_prot_a = (idx == `IDX_PROT_A);
   assign hit_prot_b = (idx == `IDX_PROT_B);
   assign hit_mfg = (idx >= `IDX_MFG_ID_FIRST)
      && (idx <= `IDX_MFG_ID_LAST);
   assign hit_status = (idx == `IDX_LINK_STATUS);
   assign req_taken = wr_taken || rd_taken;

   // Reset pulse is one cycle; stretch hides it from the bus meanwhile
   assign soft_start = wr_taken && lane0
      && hit_analog
      && AVS_WRITEDATA[`BIT_DEVICE_RESET];

   // Window length is a parameter; the bus stays busy meanwhile
   soft_reset_stretch #(
      .CYCLES(`SOFT_RESET_CYCLES)
   ) u_stretch (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .start(soft_start),
      .busy(soft_busy)
   );

   // Bus handshake: request taken in idle, answer one cycle later
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         state_reg <= BUS_IDLE;
      end else begin
         unique case (state_reg)
            BUS_IDLE: begin
               if (req_taken) begin
                  state_reg <= BUS_ANSWER;
               end
            end
            BUS_ANSWER: begin
               state_reg <= BUS_DONE;
            end
            BUS_DONE: begin
               // Dead cycle lets the master drop its request
               state_reg <= BUS_IDLE;
            end
            // Spare state code returns to idle
            default: begin
               state_reg <= BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         // Stays high through the soft reset window
         AVS_WAITREQUEST <= !(state_reg == BUS_IDLE && req_taken);
      end
   end

   // Analog control; reserved bits never stored, reset bit never held
   // Soft reset wins over the write that carries it
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         analog_control_reg <= `RST_ANALOG_CONTROL;
      end else if (soft_start) begin
         analog_control_reg <= `RST_ANALOG_CONTROL;
      end else if (wr_taken && lane0 && hit_analog) begin
         analog_control_reg <= AVS_WRITEDATA[7:0] & `ANALOG_WRITABLE_MASK;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         channel_select_reg <= `RST_CHANNEL_SELECT;
      end else if (soft_start) begin
         channel_select_reg <= `RST_CHANNEL_SELECT;
      end else if (wr_taken && lane0 && hit_channel) begin
         channel_select_reg <= AVS_WRITEDATA[7:0] & `CHANNEL_WRITABLE_MASK;
      end
   end

   // Protected register write strobes, one cycle
   // Locked writes still answer OK so the host never stalls on them
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         prot_a_we_reg <= 1'b0;
      end else begin
         prot_a_we_reg <= wr_taken && lane0 && hit_prot_a
            && analog_control_reg[`BIT_REG_WRITE_EN];
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         prot_b_we_reg <= 1'b0;
      end else begin
         prot_b_we_reg <= wr_taken && lane0 && hit_prot_b
            && analog_control_reg[`BIT_REG_WRITE_EN];
      end
   end

   // Data byte follows every write; only the strobes are gated
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         prot_wdata_reg <= 8'h00;
      end else if (wr_taken) begin
         prot_wdata_reg <= AVS_WRITEDATA[7:0];
      end
   end

   // ID byte select, lowest index takes the lowest byte
   always_comb begin
      mfg_byte = 8'h00;
      unique case (idx[1:0])
         2'b00: mfg_byte = MFG_ID[7:0];
         2'b01: mfg_byte = MFG_ID[15:8];
         2'b10: mfg_byte = MFG_ID[23:16];
         2'b11: mfg_byte = MFG_ID[31:24];
      endcase
   end

   // Read mux; unmapped words read zero with a decode error
   always_comb begin
      rdata_next = 32'h0000_0000;
      resp_next = 2'b00;
      if (hit_analog) begin
         rdata_next = {24'h000000, analog_control_reg};
      end else if (hit_channel) begin
         rdata_next = {24'h000000, channel_select_reg};
      end else if (hit_prot_a) begin
         rdata_next = {24'h000000, PROT_A_RDATA};
      end else if (hit_prot_b) begin
         rdata_next = {24'h000000, PROT_B_RDATA};
      end else if (hit_mfg) begin
         // Gated reads return zero rather than stale ID data
         if (analog_control_reg[`BIT_MFG_READ_EN]) begin
            rdata_next = {24'h000000, mfg_byte};
         end
      end else if (hit_status) begin
         rdata_next = {29'h0, amp_oe_reg, amp_pin_reg, soft_busy};
      end else begin
         resp_next = 2'b11;
      end
   end

   // Read data holds until the next request; writes clear stale bytes
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_taken) begin
         rdata_reg <= rdata_next;
      end else if (wr_taken) begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   // Writes to unmapped words report a decode error as reads do
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         resp_reg <= 2'b00;
      end else if (req_taken) begin
         resp_reg <= resp_next;
      end
   end

   // Amplifier pin: enable from bit 2; the polarity bit reaches the pin even while disabled
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         amp_oe_reg <= 1'b0;
      end else begin
         amp_oe_reg <= analog_control_reg[`BIT_AMP_OUTPUT_ENABLE];
      end
   end

   // Pin carries the idle level; a set bit makes it active low
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         amp_pin_reg <= 1'b0;
      end else begin
         amp_pin_reg <= analog_control_reg[`BIT_AMP_INVERT];
      end
   end

   // Frequency word registered so the synthesizer sees a clean value
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         freq_reg <= `BASE_FREQ_MHZ;
      end else begin
         freq_reg <= `BASE_FREQ_MHZ
            + {5'h00, channel_select_reg[6:0]};
      end
   end

   // Radio core held in reset as long as the soft reset window, starting and ending one cycle after it
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         dev_rst_b_reg <= 1'b0;
      end else begin
         dev_rst_b_reg <= !soft_busy;
      end
   end

   // Every output leaves straight from a flop
   assign AVS_READDATA = rdata_reg;
   assign AVS_RESPONSE = resp_reg;
   assign PROT_A_WE = prot_a_we_reg;
   assign PROT_B_WE = prot_b_we_reg;
   assign PROT_WDATA = prot_wdata_reg;
   // Power for the ID store follows the enable bit; host keeps it short
   assign MFG_ID_POWER = analog_control_reg[`BIT_MFG_READ_EN];
   assign amp_control_pin = amp_pin_reg;
   assign amp_control_pin_oe = amp_oe_reg;
   assign SYNTH_CHANNEL = channel_select_reg[6:0];
   assign SYNTH_FREQ_MHZ = freq_reg;
   assign DEVICE_RESET_B = dev_rst_b_reg;
endmodule

// [bench/radio_regs_chk.sv]
// Purpose: Port assertions for the radio config registers
// Assumes: Host keeps reserved bits zero
// Notes: Bound at the foot of this file
`include "radio_regs_consts.svh"
module radio_regs_chk #(parameter int ADDR_W = 8) (
   // Clock, reset, bus
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic [ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   // Radio side
   input wire logic PROT_A_WE,
   input wire logic [31:0] MFG_ID,
   input wire logic MFG_ID_POWER,
   input wire logic amp_control_pin,
   input wire logic amp_control_pin_oe,
   input wire logic [6:0] SYNTH_CHANNEL,
   input wire logic [11:0] SYNTH_FREQ_MHZ,
   input wire logic DEVICE_RESET_B
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   // Answered analog write that is not a soft reset
   wire logic ana_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
      && AVS_ADDRESS == `IDX_ANALOG_CONTROL && !AVS_WRITEDATA[0];
   property p_prot;
      PROT_A_WE |-> $past(AVS_WRITE) && $past(AVS_ADDRESS) == `IDX_PROT_A;
   endproperty
   a_prot: assert property (p_prot) else $error("stray strobe");
   property p_mfg;
      AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `IDX_MFG_ID_FIRST |->
         AVS_READDATA == (MFG_ID_POWER ? {24'h0, MFG_ID[7:0]} : 32'h0);
   endproperty
   a_mfg: assert property (p_mfg) else $error("id read");
   property p_oe;
      ana_wr |=> amp_control_pin_oe == $past(AVS_WRITEDATA[2]);
   endproperty
   a_oe: assert property (p_oe) else $error("amp enable");
   property p_pin;
      ana_wr |=> amp_control_pin == $past(AVS_WRITEDATA[1]);
   endproperty
   a_pin: assert property (p_pin) else $error("amp polarity");
   property p_soft;
      $fell(DEVICE_RESET_B) |-> ##[1:8] DEVICE_RESET_B;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset stuck");
   property p_freq;
      SYNTH_FREQ_MHZ == `BASE_FREQ_MHZ + $past(SYNTH_CHANNEL);
   endproperty
   a_freq: assert property (p_freq) else $error("freq");
   property p_rbit;
      AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `IDX_ANALOG_CONTROL
         |-> AVS_READDATA[0] == 1'b0;
   endproperty
   a_rbit: assert property (p_rbit) else $error("reset bit");
endmodule
bind radio_analog_channel_regs radio_regs_chk #(.ADDR_W(ADDR_W))
   radio_regs_chk_inst (.*);

// [bench/radio_host.sv]
// Purpose: Host MCU model on the register bus
// Assumes: One request at a time
// Notes: Reserved bits forced to zero, channel kept legal
module radio_host (
   // Bus
   input wire logic CLK_SYS,
   output logic [7:0] AVS_ADDRESS = 8'h00,
   output logic AVS_READ = 1'b0,
   output logic AVS_WRITE = 1'b0,
   output logic [31:0] AVS_WRITEDATA = 32'h0,
   output logic [3:0] AVS_BYTEENABLE = 4'h1,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic [1:0] AVS_RESPONSE
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] rdata;
   logic [1:0] rsp;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      if (w && a == 8'h20) d = d & 8'h67;
      if (w && a == 8'h21 && (d < 8'd2 || d > 8'd79)) d = 8'd2;
      @(posedge CLK_SYS);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= {24'h0, d};
      AVS_WRITE <= w;
      AVS_READ <= !w;
      do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0 && ++n < 40);
      rdata = AVS_READDATA;
      rsp = AVS_RESPONSE;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      if (n >= 40) begin
         testbench.miscompares++;
         testbench.conclude();
      end
   endtask
endmodule

// [bench/testbench.sv]
// Purpose: Self-checking bench for the radio config registers
// Assumes: Host model owns the bus
// Notes: Seeded random channels and ID bytes
`include "radio_regs_consts.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK_SYS = 1'b0;
   logic RST_B = 1'b0;
   logic [7:0] PROT_A_RDATA = 8'h00, PROT_B_RDATA = 8'h00, c;
   logic [31:0] MFG_ID = 32'h0;
   wire AVS_READ, AVS_WRITE, AVS_WAITREQUEST, PROT_A_WE, PROT_B_WE;
   wire MFG_ID_POWER, amp_control_pin, amp_control_pin_oe, DEVICE_RESET_B;
   wire [7:0] AVS_ADDRESS, PROT_WDATA;
   wire [31:0] AVS_WRITEDATA, AVS_READDATA;
   wire [3:0] AVS_BYTEENABLE;
   wire [1:0] AVS_RESPONSE;
   wire [6:0] SYNTH_CHANNEL;
   wire [11:0] SYNTH_FREQ_MHZ;
   int checks = 0, miscompares = 0, np = 0, i;
   always #2.5 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) if (PROT_A_WE || PROT_B_WE) np++;
   radio_analog_channel_regs radio_analog_channel_regs_inst (.*);
   radio_host radio_host_inst (.*);
   function automatic logic [11:0] freq(input logic [7:0] ch);
      return `BASE_FREQ_MHZ + {4'h0, ch};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      radio_host_inst.xfer(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      radio_host_inst.xfer(1'b0, a, 8'h00);
      `CHK("readdata", {24'h0, e}, radio_host_inst.rdata)
   endtask
   task conclude();
      if (miscompares == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      i = $urandom(32'hd792253e);
      repeat (5) @(posedge CLK_SYS);
      RST_B <= 1'b1;
      rchk(`IDX_ANALOG_CONTROL, 8'h00);
      rchk(8'h55, 8'h00);
      `CHK("response", 2'b11, radio_host_inst.rsp)
      for (i = 0; i < 8; i++) begin
         c = i == 0 ? 8'd2 : i == 1 ? 8'd79 : 8'd2 + 8'($urandom % 78);
         wr(`IDX_CHANNEL_SELECT, c);
         rchk(`IDX_CHANNEL_SELECT, c);
         `CHK("freq", freq(c), SYNTH_FREQ_MHZ)
         `CHK("channel", c[6:0], SYNTH_CHANNEL)
      end
      PROT_A_RDATA <= 8'($urandom);
      MFG_ID <= $urandom;
      wr(`IDX_ANALOG_CONTROL, 8'h40);
      wr(`IDX_PROT_A, 8'h5a);
      wr(`IDX_PROT_B, 8'ha5);
      `CHK("prot wdata", 8'ha5, PROT_WDATA)
      rchk(`IDX_PROT_A, PROT_A_RDATA);
      wr(`IDX_ANALOG_CONTROL, 8'h00);
      wr(`IDX_PROT_A, 8'h11);
      repeat (2) @(posedge CLK_SYS);
      `CHK("strobes", 2, np)
      wr(`IDX_ANALOG_CONTROL, 8'h20);
      `CHK("id power", 1'b1, MFG_ID_POWER)
      for (i = 0; i < 4; i++)
         rchk(`IDX_MFG_ID_FIRST + 8'(i), MFG_ID[8*i +: 8]);
      wr(`IDX_ANALOG_CONTROL, 8'h00);
      `CHK("id power", 1'b0, MFG_ID_POWER)
      rchk(8'h3d, 8'h00);
      // Enable and polarity move in separate writes
      for (i = 0; i < 3; i++) begin
         c = i == 0 ? 8'h04 : i == 1 ? 8'h06 : 8'h02;
         wr(`IDX_ANALOG_CONTROL, c);
         rchk(`IDX_ANALOG_CONTROL, c);
         `CHK("amp oe", c[2], amp_control_pin_oe)
         `CHK("amp pin", c[1], amp_control_pin)
         rchk(`IDX_LINK_STATUS, {5'h00, c[2:1], 1'b0});
      end
      wr(`IDX_CHANNEL_SELECT, 8'd40);
      wr(`IDX_ANALOG_CONTROL, 8'h01);
      @(posedge CLK_SYS);
      `CHK("device reset", 1'b0, DEVICE_RESET_B)
      rchk(`IDX_ANALOG_CONTROL, 8'h00);
      rchk(`IDX_CHANNEL_SELECT, 8'h00);
      `CHK("device reset", 1'b1, DEVICE_RESET_B)
      `CHK("amp pin", 1'b0, amp_control_pin)
      `CHK("freq", freq(8'h00), SYNTH_FREQ_MHZ)
      conclude();
   end
endmodule
